// ---- mca_top.sv ----
// Four-channel counter, encoder and delayed alarm input unit
// Assumes APB master on clk_sys_in; inputs asynchronous to the pins
`timescale 1ns/1ps
`default_nettype none
module mca_top #(
	parameter int DLY01 = mca_pkg::CYC01,
	parameter int DLY05 = mca_pkg::CYC05,
	parameter int DLY3 = mca_pkg::CYC3,
	parameter int DLY15 = mca_pkg::CYC15
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	// APB
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Inputs of the input connector
	input wire logic [3:0] input_connector_in,
	// Alarm event level (any pending)
	output logic alarm_out
);
	import mca_pkg::*;

	initial begin
		if (DLY01 < 1 || DLY05 < DLY01 || DLY3 < DLY05 || DLY15 < DLY3 || DLY15 > 2**24)
			$error("mca_top: bad delay counts");
	end

	// ------------------------------------------------------------
	// Sync and edges
	// ------------------------------------------------------------
	logic [3:0] s1_r, s2_r, s3_r;
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			s1_r <= 4'h0;
			s2_r <= 4'h0;
			s3_r <= 4'h0;
		end else begin
			s1_r <= input_connector_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	wire logic [3:0] rise = s2_r & ~s3_r;
	wire logic [3:0] fall = ~s2_r & s3_r;
	wire logic [3:0] lvl = s2_r;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [12:0] cfg_r [4];
	logic [31:0] cnt_r [4];
	logic [31:0] lim_r [4];
	logic [31:0] pre_r [4];
	logic [3:0] alst_r;
	logic [23:0] tmr_r [4];
	logic [3:0] arm_r;

	function automatic logic [23:0] dly_cnt(input logic [3:0] f);
		case (f)
			FN_AL01: dly_cnt = 24'(DLY01);
			FN_AL05: dly_cnt = 24'(DLY05);
			FN_AL3: dly_cnt = 24'(DLY3);
			FN_AL15: dly_cnt = 24'(DLY15);
			default: dly_cnt = 24'h00_0000;
		endcase
	endfunction

	function automatic logic is_cnt(input logic [3:0] f);
		is_cnt = (f >= FN_PULSE) && (f <= FN_GATE);
	endfunction

	function automatic logic is_enc(input logic [3:0] f);
		is_enc = (f >= FN_ENC1) && (f <= FN_ENC4);
	endfunction

	wire logic acc = psel_in & penable_in;
	wire logic wr = acc & pwrite_in;
	wire logic [1:0] ix = paddr_in[3:2];
	wire logic hit_cfg = paddr_in[7:4] == MCA_CFG0[7:4];
	wire logic hit_cnt = paddr_in[7:4] == MCA_CNT0[7:4];
	wire logic hit_lim = paddr_in[7:4] == MCA_LIM0[7:4];
	wire logic hit_pre = paddr_in[7:4] == MCA_PRE0[7:4];
	wire logic hit_cmd = paddr_in == MCA_PRECMD;
	wire logic hit_ast = paddr_in == MCA_ALST;
	wire logic hit_ins = paddr_in == MCA_INST;
	wire logic mapped = hit_cfg | hit_cnt | hit_lim | hit_pre | hit_cmd | hit_ast | hit_ins;
	wire logic [3:0] preload = (wr && hit_cmd) ? pwdata_in[3:0] : 4'h0;

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			for (int i = 0; i < 4; i++) begin
				cfg_r[i] <= 13'h0000;
				lim_r[i] <= MCA_CNT_RST;
				pre_r[i] <= MCA_CNT_RST;
			end
		end else if (wr) begin
			if (hit_cfg)
				cfg_r[ix] <= pwdata_in[12:0];
			if (hit_lim)
				lim_r[ix] <= pwdata_in;
			if (hit_pre)
				pre_r[ix] <= pwdata_in;
		end
	end

	// APB answer: one-cycle access phase
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			prdata_out <= 32'h0000_0000;
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
		end else begin
			pready_out <= psel_in & ~penable_in;
			pslverr_out <= psel_in & ~penable_in & ~mapped;
			prdata_out <= 32'h0000_0000;
			if (psel_in && !penable_in && !pwrite_in) begin
				if (hit_cfg)
					prdata_out <= {19'h0_0000, cfg_r[ix]};
				else if (hit_cnt)
					prdata_out <= cnt_r[ix];
				else if (hit_lim)
					prdata_out <= lim_r[ix];
				else if (hit_pre)
					prdata_out <= pre_r[ix];
				else if (hit_ast)
					prdata_out <= {28'h000_0000, alst_r};
				else if (hit_ins)
					prdata_out <= {28'h000_0000, lvl};
			end
		end
	end

	// ------------------------------------------------------------
	// Count steps
	// ------------------------------------------------------------
	logic [3:0] up, dn, lhit;
	always_comb begin
		up = 4'h0;
		dn = 4'h0;
		for (int i = 0; i < 4; i++) begin
			logic [1:0] b;
			logic ev, pol;
			logic [3:0] f;
			b = 2'(i ^ 1);
			f = cfg_r[i][3:0];
			pol = cfg_r[i][MCA_F_DIR];
			ev = (cfg_r[i][MCA_F_EDGE] & rise[i]) | (cfg_r[i][MCA_F_EDGE+1] & fall[i]);
			// Encoders and paired modes only on channels 0 and 2
			case (f)
				FN_PULSE: begin
					up[i] = ev & ~pol;
					dn[i] = ev & pol;
				end
				FN_PDIR: if (i % 2 == 0) begin
					up[i] = ev & (lvl[b] == pol);
					dn[i] = ev & (lvl[b] != pol);
				end
				FN_GATE: if (i % 2 == 0) begin
					up[i] = ev & lvl[b] & ~pol;
					dn[i] = ev & lvl[b] & pol;
				end
				FN_ENC1: if (i % 2 == 0) begin
					up[i] = fall[i] & lvl[b];
					dn[i] = rise[i] & lvl[b];
				end
				FN_ENC2: if (i % 2 == 0) begin
					up[i] = (rise[i] & ~lvl[b]) | (fall[i] & lvl[b]);
					dn[i] = (rise[i] & lvl[b]) | (fall[i] & ~lvl[b]);
				end
				FN_ENC4: if (i % 2 == 0) begin
					up[i] = (rise[b] & lvl[i]) | (fall[b] & ~lvl[i])
						| (rise[i] & ~lvl[b]) | (fall[i] & lvl[b]);
					dn[i] = (rise[b] & ~lvl[i]) | (fall[b] & lvl[i])
						| (rise[i] & lvl[b]) | (fall[i] & ~lvl[b]);
				end
				default: begin
					up[i] = 1'b0;
					dn[i] = 1'b0;
				end
			endcase
		end
	end

	// Second input of a pair is busy if the first uses it
	wire logic [3:0] slave_in = {is_cnt(cfg_r[2][3:0]) && cfg_r[2][3:0] != FN_PULSE,
		1'b0, is_cnt(cfg_r[0][3:0]) && cfg_r[0][3:0] != FN_PULSE, 1'b0};
	// Encoders take over their B input, alarm function included
	wire logic [3:0] enc_b = {is_enc(cfg_r[2][3:0]), 1'b0, is_enc(cfg_r[0][3:0]), 1'b0};

	// ------------------------------------------------------------
	// Counters
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		for (int i = 0; i < 4; i++) begin
			if (!nrst_in) begin
				cnt_r[i] <= MCA_CNT_RST;
				lhit[i] <= 1'b0;
			end else begin
				lhit[i] <= 1'b0;
				if (preload[i]) begin
					cnt_r[i] <= pre_r[i];
				end else if (up[i] && !slave_in[i]) begin
					if (cfg_r[i][MCA_F_ULIM] && cnt_r[i] + 32'h0000_0001 >= lim_r[i]) begin
						cnt_r[i] <= MCA_CNT_RST;
						lhit[i] <= 1'b1;
					end else begin
						cnt_r[i] <= cnt_r[i] + 32'h0000_0001;
					end
				end else if (dn[i] && !slave_in[i]) begin
					if (cfg_r[i][MCA_F_LLIM] && cnt_r[i] == MCA_CNT_RST + 32'h0000_0001) begin
						cnt_r[i] <= lim_r[i];
						lhit[i] <= 1'b1;
					end else begin
						cnt_r[i] <= cnt_r[i] - 32'h0000_0001;
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Delayed alarm inputs
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		for (int i = 0; i < 4; i++) begin
			logic [3:0] f;
			logic clr;
			f = cfg_r[i][3:0];
			clr = wr && hit_ast && pwdata_in[i];
			if (!nrst_in) begin
				tmr_r[i] <= 24'h00_0000;
				arm_r[i] <= 1'b0;
				alst_r[i] <= 1'b0;
			end else begin
				if (lhit[i] && cfg_r[i][MCA_F_LALM]) begin
					alst_r[i] <= 1'b1;
				end else if (clr) begin
					alst_r[i] <= 1'b0;
				end
				if (f >= FN_AL0 && f <= FN_AL15 && !enc_b[i]) begin
					if ((cfg_r[i][MCA_F_EDGE] & rise[i]) || (cfg_r[i][MCA_F_EDGE+1] & fall[i])) begin
						arm_r[i] <= 1'b1;
						tmr_r[i] <= dly_cnt(f);
						if (dly_cnt(f) == 24'h00_0000) begin
							arm_r[i] <= 1'b0;
							alst_r[i] <= 1'b1;
						end
					end else if (arm_r[i] && (rise[i] || fall[i])) begin
						arm_r[i] <= 1'b0;
					end else if (arm_r[i]) begin
						if (tmr_r[i] <= 24'h00_0001) begin
							arm_r[i] <= 1'b0;
							alst_r[i] <= 1'b1;
						end else begin
							tmr_r[i] <= tmr_r[i] - 24'h00_0001;
						end
					end
				end else begin
					arm_r[i] <= 1'b0;
					tmr_r[i] <= 24'h00_0000;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in)
			alarm_out <= 1'b0;
		else
			alarm_out <= |alst_r;
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_reset_clear;
		@(posedge clk_sys_in) !nrst_in |=> cnt_r[0] == 32'h0000_0000 && alst_r == 4'h0;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear");

	property p_off_still;
		@(posedge clk_sys_in) disable iff (!nrst_in)
			cfg_r[1][3:0] == FN_OFF && !preload[1] |=> $stable(cnt_r[1]);
	endproperty
	a_off_still: assert property (p_off_still) else $error("disabled counter moved");

	property p_pulse_up;
		@(posedge clk_sys_in) disable iff (!nrst_in)
			cfg_r[1][3:0] == FN_PULSE && !cfg_r[1][MCA_F_DIR] && cfg_r[1][5:4] == 2'b01
			&& rise[1] && !cfg_r[1][MCA_F_ULIM] && !preload[1] && !slave_in[1]
			|=> cnt_r[1] == $past(cnt_r[1]) + 32'h0000_0001;
	endproperty
	a_pulse_up: assert property (p_pulse_up) else $error("pulse not counted");

	property p_wrap;
		@(posedge clk_sys_in) disable iff (!nrst_in)
			dn[3] && !slave_in[3] && !preload[3] && !cfg_r[3][MCA_F_LLIM]
			&& cnt_r[3] == 32'h0000_0000 |=> cnt_r[3] == 32'hFFFF_FFFF;
	endproperty
	a_wrap: assert property (p_wrap) else $error("no wrap to all ones");

	property p_dir_up;
		@(posedge clk_sys_in) disable iff (!nrst_in)
			cfg_r[0][3:0] == FN_PDIR && !cfg_r[0][MCA_F_DIR] && rise[0]
			&& cfg_r[0][MCA_F_EDGE] && !lvl[1] |-> up[0] && !dn[0];
	endproperty
	a_dir_up: assert property (p_dir_up) else $error("direction polarity wrong");

	property p_enc1;
		@(posedge clk_sys_in) disable iff (!nrst_in)
			cfg_r[0][3:0] == FN_ENC1 && fall[0] && lvl[1] |-> up[0];
	endproperty
	a_enc1: assert property (p_enc1) else $error("single encoder missed");

	property p_enc4;
		@(posedge clk_sys_in) disable iff (!nrst_in)
			cfg_r[0][3:0] == FN_ENC4 && rise[1] && !lvl[0] |-> dn[0];
	endproperty
	a_enc4: assert property (p_enc4) else $error("quad encoder missed");

	property p_preset;
		@(posedge clk_sys_in) disable iff (!nrst_in)
			preload[3] |=> cnt_r[3] == $past(pre_r[3]);
	endproperty
	a_preset: assert property (p_preset) else $error("preset not loaded");

	property p_no_early;
		@(posedge clk_sys_in) disable iff (!nrst_in)
			arm_r[1] && tmr_r[1] > 24'h00_0001 && !lhit[1] |=> !$rose(alst_r[1]);
	endproperty
	a_no_early: assert property (p_no_early) else $error("alarm before delay");

	property p_apb;
		@(posedge clk_sys_in) disable iff (!nrst_in)
			psel_in && !penable_in |=> pready_out;
	endproperty
	a_apb: assert property (p_apb) else $error("apb no ready");

	c_enc2: cover property (@(posedge clk_sys_in) cfg_r[0][3:0] == FN_ENC2 && dn[0]);
	c_alarm: cover property (@(posedge clk_sys_in) $rose(alst_r[1]));
	c_limit: cover property (@(posedge clk_sys_in) lhit[0]);
	c_gate: cover property (@(posedge clk_sys_in) cfg_r[2][3:0] == FN_GATE && up[2]);
	c_dir_down: cover property (@(posedge clk_sys_in) cfg_r[0][3:0] == FN_PDIR && dn[0]);

	property p_enc_b;
		@(posedge clk_sys_in) disable iff (!nrst_in)
			is_enc(cfg_r[0][3:0]) && !preload[1] |=> $stable(cnt_r[1]);
	endproperty
	a_enc_b: assert property (p_enc_b) else $error("encoder B input counted");

	property p_gate_closed;
		@(posedge clk_sys_in) disable iff (!nrst_in)
			cfg_r[2][3:0] == FN_GATE && !lvl[3] |-> !up[2] && !dn[2];
	endproperty
	a_gate_closed: assert property (p_gate_closed) else $error("closed gate counted");

	property p_lim_alarm;
		@(posedge clk_sys_in) disable iff (!nrst_in)
			lhit[0] && cfg_r[0][MCA_F_LALM] |=> alst_r[0];
	endproperty
	a_lim_alarm: assert property (p_lim_alarm) else $error("limit alarm missing");

	property p_dir_dn;
		@(posedge clk_sys_in) disable iff (!nrst_in)
			cfg_r[0][3:0] == FN_PDIR && cfg_r[0][MCA_F_DIR] && rise[0]
			&& cfg_r[0][MCA_F_EDGE] && !lvl[1] |-> dn[0] && !up[0];
	endproperty
	a_dir_dn: assert property (p_dir_dn) else $error("down polarity wrong");
endmodule
`default_nettype wire

// ---- mca_pkg.sv ----
// Constants for the four-channel counter and alarm input unit
// Assumes a 100 MHz system clock and an APB register bus
package mca_pkg;
	// ------------------------------------------------------------
	// Registers (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] MCA_CFG0 = 8'h00;
	localparam logic [7:0] MCA_CNT0 = 8'h10;
	localparam logic [7:0] MCA_LIM0 = 8'h20;
	localparam logic [7:0] MCA_PRE0 = 8'h30;
	localparam logic [7:0] MCA_PRECMD = 8'h40;
	localparam logic [7:0] MCA_ALST = 8'h44;
	localparam logic [7:0] MCA_INST = 8'h48;
	// ------------------------------------------------------------
	// Config fields
	// ------------------------------------------------------------
	localparam int MCA_F_FUNC = 0;  // [3:0]
	localparam int MCA_F_EDGE = 4;  // [5:4] 1 rising 2 falling 3 both
	localparam int MCA_F_DIR = 6;   // 1 = polarity down
	localparam int MCA_F_ULIM = 7;
	localparam int MCA_F_LLIM = 8;
	localparam int MCA_F_LALM = 9;
	localparam int MCA_F_LO = 12;   // not read by mca_top; up limit clears to zero at LIM, down limit loads LIM from 1
	localparam logic [3:0] FN_OFF = 4'h0;
	localparam logic [3:0] FN_AL0 = 4'h1;
	localparam logic [3:0] FN_AL01 = 4'h2;
	localparam logic [3:0] FN_AL05 = 4'h3;
	localparam logic [3:0] FN_AL3 = 4'h4;
	localparam logic [3:0] FN_AL15 = 4'h5;
	localparam logic [3:0] FN_PULSE = 4'h6;
	localparam logic [3:0] FN_PDIR = 4'h7;
	localparam logic [3:0] FN_ENC1 = 4'h8;
	localparam logic [3:0] FN_ENC2 = 4'h9;
	localparam logic [3:0] FN_ENC4 = 4'hA;
	localparam logic [3:0] FN_GATE = 4'hB;
	localparam logic [31:0] MCA_CNT_RST = 32'h0000_0000;
	localparam logic [31:0] MCA_ALL1 = 32'hFFFF_FFFF;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int DLY01_US = 100;
	localparam int DLY05_US = 500;
	localparam int DLY3_US = 3000;
	localparam int DLY15_US = 15000;
	localparam int CYC01 = DLY01_US * CLK_MHZ;
	localparam int CYC05 = DLY05_US * CLK_MHZ;
	localparam int CYC3 = DLY3_US * CLK_MHZ;
	localparam int CYC15 = DLY15_US * CLK_MHZ;
endpackage

// ---- mca_src.sv ----
// Far-side source of pulses, gates, encoder tracks and switches
// Assumes callers start each step just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module mca_src #(
	parameter int MIN_GAP = 4
) (
	// Clock
	input wire logic clk_in,
	// Connector pins
	output logic [3:0] pins_out
);
	initial pins_out = 4'h0;
	// ------------------------------------------------------------
	// Level steps, each held a while
	// ------------------------------------------------------------
	task automatic set_pins(input logic [3:0] lvl, input int hold);
		pins_out <= lvl;
		repeat ((hold < MIN_GAP) ? MIN_GAP : hold) @(posedge clk_in);
	endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the counter and alarm input unit
// Assumes mca_src drives the four connector pins
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import mca_pkg::*;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam logic [31:0] B_DIR = 32'h0000_0001 << MCA_F_DIR;
	localparam logic [31:0] B_ULIM = 32'h0000_0001 << MCA_F_ULIM;
	localparam logic [31:0] B_LLIM = 32'h0000_0001 << MCA_F_LLIM;
	localparam logic [31:0] B_LALM = 32'h0000_0001 << MCA_F_LALM;
	localparam logic [31:0] Z = 32'h0000_0000;
	logic clk_sys_in = 1'b0;
	logic nrst_in = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic alarm;
	logic [3:0] pins;
	logic [32:0] expq[$];
	logic [32:0] want;
	logic [7:0] lfsr = 8'h44;
	logic [31:0] n;
	int failures = 0;
	int checks_done = 0;
	always #5 clk_sys_in = ~clk_sys_in;
	mca_src mca_src_i (.clk_in(clk_sys_in), .pins_out(pins));
	mca_top #(.DLY01(5), .DLY05(10), .DLY3(20), .DLY15(40)) mca_top_i (
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.psel_in(psel),
		.penable_in(penable),
		.pwrite_in(pwrite),
		.paddr_in(paddr),
		.pwdata_in(pwdata),
		.prdata_out(prdata),
		.pready_out(pready),
		.pslverr_out(pslverr),
		.input_connector_in(pins),
		.alarm_out(alarm)
	);
	// ------------------------------------------------------------
	// Checking
	// ------------------------------------------------------------
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_lvl(input logic exp);
		@(negedge clk_sys_in);
		chk({32'h0000_0000, alarm}, {32'h0000_0000, exp});
		@(posedge clk_sys_in);
	endtask
	always @(posedge clk_sys_in) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			want = (expq.size() > 0) ? expq.pop_front() : {33{1'bx}};
			chk({pslverr, prdata}, want);
		end
	end
	task automatic give_verdict();
		if (failures == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge clk_sys_in);
		failures++;
		give_verdict();
	end
	// ------------------------------------------------------------
	// Drivers
	// ------------------------------------------------------------
	task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr_en;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys_in);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys_in);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		expq.push_back({1'b0, e});
		apb(1'b0, a, Z);
	endtask
	task automatic clear();
		for (int i = 0; i < 4; i++)
			wr(MCA_PRE0 + 8'(4 * i), Z);
		wr(MCA_PRECMD, 32'h0000_000F);
	endtask
	task automatic pulse(input logic [3:0] m, input logic [31:0] c);
		repeat (c) begin
			mca_src_i.set_pins(pins | m, 4);
			mca_src_i.set_pins(pins & ~m, 4);
		end
	endtask
	function automatic logic [31:0] cw(input logic [3:0] f, input logic [1:0] e,
			input logic [31:0] x);
		return 32'(f) | (32'(e) << MCA_F_EDGE) | x;
	endfunction
	function automatic logic [3:0] gray(input int j);
		return 4'((j & 3) ^ ((j & 3) >> 1));
	endfunction
	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		pulse(4'hF, 2);
		for (int i = 0; i < 4; i++)
			rd(MCA_CNT0 + 8'(4 * i), MCA_CNT_RST);
		rd(MCA_ALST, Z);
		expq.push_back({1'b1, Z});
		apb(1'b0, 8'h4C, Z);
		lfsr = lfsr_next(lfsr);
		n = 32'(lfsr[2:0]) + 32'h0000_0001;
		for (int i = 0; i < 4; i++)
			wr(MCA_CFG0 + 8'(4 * i), cw(FN_PULSE, 2'h1, (i == 3) ? B_DIR : Z));
		pulse(4'hF, n);
		for (int i = 0; i < 3; i++)
			rd(MCA_CNT0 + 8'(4 * i), n);
		rd(MCA_CNT0 + 8'h0C, MCA_CNT_RST - n);
		lfsr = lfsr_next(lfsr);
		wr(MCA_PRE0, MCA_ALL1);
		wr(MCA_PRE0 + 8'h04, {24'h00_0000, lfsr});
		wr(MCA_PRECMD, 32'h0000_0003);
		rd(MCA_PRE0 + 8'h04, {24'h00_0000, lfsr});
		pulse(4'h3, 1);
		rd(MCA_CNT0, MCA_CNT_RST);
		rd(MCA_CNT0 + 8'h04, {24'h00_0000, lfsr} + 32'h0000_0001);
		clear();
		wr(MCA_CFG0, cw(FN_PDIR, 2'h1, Z));
		wr(MCA_CFG0 + 8'h04, Z);
		pulse(4'h1, 2);
		rd(MCA_CNT0, 32'h0000_0002);
		mca_src_i.set_pins(4'h2, 4);
		rd(MCA_INST, 32'h0000_0002);
		pulse(4'h1, 3);
		rd(MCA_CNT0, MCA_ALL1);
		wr(MCA_CFG0, cw(FN_PDIR, 2'h1, B_DIR));
		pulse(4'h1, 1);
		rd(MCA_CNT0, MCA_CNT_RST);
		mca_src_i.set_pins(4'h0, 4);
		pulse(4'h1, 2);
		rd(MCA_CNT0, 32'hFFFF_FFFE);
		clear();
		wr(MCA_CFG0 + 8'h08, cw(FN_GATE, 2'h1, Z));
		wr(MCA_CFG0 + 8'h0C, Z);
		pulse(4'h4, 2);
		mca_src_i.set_pins(4'h8, 4);
		pulse(4'h4, 3);
		mca_src_i.set_pins(4'h0, 4);
		rd(MCA_CNT0 + 8'h08, 32'h0000_0003);
		for (int k = 0; k < 3; k++) begin
			clear();
			wr(MCA_CFG0, cw(FN_ENC1 + 4'(k), 2'h0, Z));
			wr(MCA_CFG0 + 8'h04, cw(FN_PULSE, 2'h3, Z));
			for (int j = 1; j < 5; j++)
				mca_src_i.set_pins(gray(j), 4);
			rd(MCA_CNT0, 32'h0000_0001 << k);
			rd(MCA_CNT0 + 8'h04, MCA_CNT_RST);
			for (int j = 7; j >= 0; j--)
				mca_src_i.set_pins(gray(j), 4);
			rd(MCA_CNT0, Z - (32'h0000_0001 << k));
		end
		clear();
		wr(MCA_CFG0 + 8'h04, Z);
		wr(MCA_LIM0, 32'h0000_0003);
		wr(MCA_CFG0, cw(FN_PULSE, 2'h1, B_ULIM | B_LALM));
		rd(MCA_LIM0, 32'h0000_0003);
		rd(MCA_CFG0, cw(FN_PULSE, 2'h1, B_ULIM | B_LALM));
		pulse(4'h1, 2);
		rd(MCA_CNT0, 32'h0000_0002);
		rd(MCA_ALST, Z);
		pulse(4'h1, 1);
		rd(MCA_CNT0, MCA_CNT_RST);
		rd(MCA_ALST, 32'h0000_0001);
		chk_lvl(1'b1);
		wr(MCA_ALST, 32'h0000_0001);
		repeat (2) @(posedge clk_sys_in);
		chk_lvl(1'b0);
		wr(MCA_PRE0, 32'h0000_0001);
		wr(MCA_PRECMD, 32'h0000_0001);
		wr(MCA_CFG0, cw(FN_PULSE, 2'h1, B_DIR | B_LLIM));
		pulse(4'h1, 1);
		rd(MCA_CNT0, 32'h0000_0003);
		rd(MCA_ALST, Z);
		wr(MCA_CFG0, Z);
		for (int k = 0; k < 5; k++) begin
			wr(MCA_CFG0 + 8'h04, cw(FN_AL0 + 4'(k), 2'h1, Z));
			if (k > 1) begin
				mca_src_i.set_pins(4'h2, (5 << (k - 1)) / 2);
				mca_src_i.set_pins(4'h0, 50);
				rd(MCA_ALST, Z);
			end
			mca_src_i.set_pins(4'h2, (k == 0) ? 8 : (5 << (k - 1)) + 8);
			rd(MCA_ALST, 32'h0000_0002);
			chk_lvl(1'b1);
			wr(MCA_ALST, 32'h0000_0002);
			mca_src_i.set_pins(4'h0, 8);
		end
		for (int e = 1; e < 4; e++) begin
			wr(MCA_CFG0 + 8'h04, cw(FN_AL01, 2'(e), Z));
			mca_src_i.set_pins(4'h2, 20);
			rd(MCA_ALST, {30'h0, e[0], 1'b0});
			wr(MCA_ALST, 32'h0000_0002);
			mca_src_i.set_pins(4'h0, 20);
			rd(MCA_ALST, {30'h0, e[1], 1'b0});
			wr(MCA_ALST, 32'h0000_0002);
		end
		mca_src_i.set_pins(4'h2, 20);
		nrst_in <= 1'b0;
		mca_src_i.set_pins(4'h0, 4);
		nrst_in <= 1'b1;
		rd(MCA_CNT0, MCA_CNT_RST);
		rd(MCA_ALST, Z);
		chk_lvl(1'b0);
		repeat (4) @(posedge clk_sys_in);
		if (expq.size() != 0)
			failures++;
		give_verdict();
	end
endmodule
`default_nettype wire
